// ==== rtl/gyro_cmd_regs.svh ====
// character codes, sizes and error numbers of the serial command parser
`ifndef GYRO_CMD_REGS_SVH
`define GYRO_CMD_REGS_SVH
`define CH_BS 8'h08
`define CH_CR 8'h0d
`define CH_SP 8'h20
`define CH_COMMA 8'h2c
`define CH_GT 8'h3e
`define CH_UP_C 8'h43
`define CH_UP_E 8'h45
`define CH_UP_R 8'h52
`define CH_ZERO 8'h30
`define KEYWORD 88'h53_45_52_56_49_43_45_4d_4f_44_45
`define KEYWORD_LEN 4'hb
`define CMD_BUF_LEN 80
`define TX_FIFO_DEPTH 32
`define ERR_UNKNOWN 8'h01
`define ERR_SYNTAX 8'h02
`endif

// ==== rtl/gyro_cmd_pkg.sv ====
// types of the serial command parser
package gyro_cmd_pkg;
  typedef enum logic [4:0] {
    S_IDLE   = 5'h01,
    S_ERR    = 5'h02,
    S_EXEC   = 5'h04,
    S_PROMPT = 5'h08,
    S_INFO   = 5'h10
  } state_t;
  typedef enum logic [1:0] {
    MSG_UNKNOWN = 2'h0,
    MSG_SYNTAX  = 2'h1,
    MSG_PARAM   = 2'h2
  } msg_t;
endpackage

// ==== rtl/char_fifo.sv ====
// character fifo with registered output stage
`timescale 1ns/1ps
module char_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // write side
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  // read side
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out,
  // fill level of the store
  output logic [$clog2(DEPTH+1)-1:0] level_out
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH+1);
  if (DEPTH < 4 || WIDTH < 1) begin : g_chk
    $error("char_fifo: unsupported size");
  end
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wr_q;
  logic [PW-1:0] rd_q;
  logic [CW-1:0] cnt_q;
  logic ov_q;
  logic [WIDTH-1:0] od_q;
  wire push = in_valid_in && (cnt_q < CW'(DEPTH));
  wire pop = (cnt_q != '0) && (!ov_q || out_ready_in);
  wire [PW-1:0] wr_nx = (wr_q == PW'(DEPTH-1)) ? '0 : wr_q + PW'(1);
  wire [PW-1:0] rd_nx = (rd_q == PW'(DEPTH-1)) ? '0 : rd_q + PW'(1);
  assign in_ready_out = cnt_q < CW'(DEPTH);
  assign out_valid_out = ov_q;
  assign out_data_out = od_q;
  assign level_out = cnt_q;
  always_ff @(posedge clk_in) begin
    if (push) begin
      mem[wr_q] <= in_data_in;
    end
  end
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
      ov_q <= 1'b0;
      od_q <= '0;
    end else begin
      if (push) wr_q <= wr_nx;
      if (pop) rd_q <= rd_nx;
      cnt_q <= cnt_q + CW'(push) - CW'(pop);
      if (pop) begin
        od_q <= mem[rd_q];
        ov_q <= 1'b1;
      end else if (out_ready_in) begin
        ov_q <= 1'b0;
      end
    end
  end
endmodule // char_fifo

// ==== rtl/gyro_serial_command_parser.sv ====
// serial command interpreter for streaming and maintenance modes
`timescale 1ns/1ps
`include "gyro_cmd_regs.svh"
module gyro_serial_command_parser #(
  parameter int BUF_LEN = `CMD_BUF_LEN,
  parameter int FIFO_DEPTH = `TX_FIFO_DEPTH
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // received characters
  input wire logic rx_valid_in,
  input wire logic [7:0] rx_data_in,
  output logic rx_ready_out,
  // transmitted characters
  output logic tx_valid_out,
  input wire logic tx_ready_in,
  output logic [7:0] tx_data_out,
  // datagram scheduler
  input wire logic ext_trig_mode_in,
  input wire logic slot_in,
  input wire logic ext_trig_in,
  input wire logic dgram_busy_in,
  input wire logic err_dgram_done_in,
  output logic send_config_out,
  output logic send_exterr_out,
  output logic clear_errors_out,
  output logic unit_reset_out,
  output logic maint_mode_out,
  output logic measure_drop_out,
  // maintenance command executor
  output logic info_req_out,
  output logic cmd_valid_out,
  output logic [7:0] cmd_letter_out,
  output logic [6:0] param_len_out,
  input wire logic [6:0] param_addr_in,
  output logic [7:0] param_data_out,
  input wire logic cmd_done_in,
  input wire logic [7:0] cmd_err_in,
  input wire logic exit_maint_in
);
  localparam int LW = 7;
  localparam int FW = $clog2(FIFO_DEPTH+1);
  if (BUF_LEN < 2 || BUF_LEN > 127 || FIFO_DEPTH < 4) begin : g_chk
    $error("gyro_serial_command_parser: unsupported size");
  end

  // ----------------------------------------------------------
  // helpers
  // ----------------------------------------------------------
  function automatic logic [7:0] kw_byte(input logic [3:0] i);
    kw_byte = 8'(`KEYWORD >> (8 * (10 - int'(i))));
  endfunction
  function automatic logic is_cmd(input logic [7:0] c);
    case (c)
      "i", "a", "c", "d", "t", "r", "u", "f", "m", "s", "x", "z", "?":
        is_cmd = 1'b1;
      default: is_cmd = 1'b0;
    endcase
  endfunction
  function automatic logic [7:0] dec_digit(input logic [7:0] v,
                                           input logic [1:0] p);
    logic [7:0] d;
    d = 8'h00;
    case (p)
      2'h0: d = v / 8'd100;
      2'h1: d = (v / 8'd10) % 8'd10;
      default: d = v % 8'd10;
    endcase
    dec_digit = `CH_ZERO + d;
  endfunction
  function automatic logic [4:0] msg_len(input gyro_cmd_pkg::msg_t k);
    case (k)
      gyro_cmd_pkg::MSG_UNKNOWN: msg_len = 5'd15;
      gyro_cmd_pkg::MSG_SYNTAX: msg_len = 5'd10;
      default: msg_len = 5'd17;
    endcase
  endfunction
  function automatic logic [7:0] msg_char(input gyro_cmd_pkg::msg_t k,
                                          input logic [4:0] i);
    logic [8*17-1:0] t;
    t = '0;
    case (k)
      gyro_cmd_pkg::MSG_UNKNOWN: t = "UNKNOWN COMMAND";
      gyro_cmd_pkg::MSG_SYNTAX: t = "BAD SYNTAX";
      default: t = "INVALID PARAMETER";
    endcase
    msg_char = 8'(t >> (8 * (int'(msg_len(k)) - 1 - int'(i))));
  endfunction

  // ----------------------------------------------------------
  // state
  // ----------------------------------------------------------
  gyro_cmd_pkg::state_t state_q, state_d;
  gyro_cmd_pkg::msg_t kind_q, kind_d;
  logic [7:0] code_q, code_d;
  logic [4:0] idx_q;
  logic [7:0] cbuf [BUF_LEN];
  logic [LW-1:0] m_len_q;
  logic [3:0] s_len_q;
  logic kw_ok_q;
  logic [7:0] first_q;
  logic cfg_pend_q, err_pend_q, maint_req_q, maint_q;
  logic rx_ready_q;
  logic trig_s1_q, trig_s2_q, trig_s3_q;
  logic send_cfg_q, send_err_q, clr_err_q, reset_q, info_q, cmd_v_q;
  logic [7:0] letter_q, pdata_q;
  logic [LW-1:0] plen_q;
  logic [FW-1:0] fifo_level;
  logic fifo_ready;

  // ----------------------------------------------------------
  // decode
  // ----------------------------------------------------------
  wire rx_take = rx_valid_in && rx_ready_q;
  wire is_cr = rx_data_in == `CH_CR;
  wire s_take = rx_take && !maint_q;
  wire m_take = rx_take && maint_q && state_q == gyro_cmd_pkg::S_IDLE;
  wire s_one = s_take && is_cr && s_len_q == 4'h1;
  wire req_cfg = s_one && first_q == `CH_UP_C;
  wire req_err = s_one && first_q == `CH_UP_E;
  wire req_rst = s_one && first_q == `CH_UP_R;
  wire req_kw = s_take && is_cr && s_len_q == `KEYWORD_LEN && kw_ok_q;
  wire trig_edge = trig_s2_q && !trig_s3_q;
  wire slot = ext_trig_mode_in ? trig_edge : slot_in;
  wire enter = maint_req_q && !dgram_busy_in;
  wire m_cr = m_take && is_cr;
  wire m_bs = m_take && rx_data_in == `CH_BS;
  wire m_store = m_take && !is_cr && !m_bs && m_len_q < LW'(BUF_LEN);
  wire known = is_cmd(cbuf[0]);
  wire syn_ok = m_len_q == LW'(1) || cbuf[1] == `CH_SP;
  wire [4:0] err_last = 5'd5 + msg_len(kind_q);
  wire [7:0] err_ch = (idx_q == 5'd0) ? `CH_UP_E :
                      (idx_q < 5'd4) ? dec_digit(code_q, 2'(idx_q - 5'd1)) :
                      (idx_q == 5'd4) ? `CH_SP :
                      (idx_q == err_last) ? `CH_CR :
                      msg_char(kind_q, idx_q - 5'd5);
  wire in_err = state_q == gyro_cmd_pkg::S_ERR;
  wire in_prompt = state_q == gyro_cmd_pkg::S_PROMPT;
  wire emit = (in_err || in_prompt) && fifo_ready;
  wire wr_valid = m_take || emit;
  wire [7:0] prompt_ch = idx_q == 5'd0 ? `CH_CR : `CH_GT;
  wire [7:0] wr_data = m_take ? rx_data_in :
                       in_err ? err_ch : prompt_ch;
  wire emit_last = (in_err && idx_q == err_last) ||
                   (in_prompt && idx_q == 5'd1);

  // ----------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------
  always_comb begin
    state_d = state_q;
    kind_d = kind_q;
    code_d = code_q;
    case (state_q)
      gyro_cmd_pkg::S_IDLE: begin
        if (!maint_q && enter) begin
          state_d = gyro_cmd_pkg::S_INFO;
        end else if (m_cr) begin
          if (m_len_q == '0) begin
            state_d = gyro_cmd_pkg::S_PROMPT;
          end else if (!known) begin
            state_d = gyro_cmd_pkg::S_ERR;
            kind_d = gyro_cmd_pkg::MSG_UNKNOWN;
            code_d = `ERR_UNKNOWN;
          end else if (!syn_ok) begin
            state_d = gyro_cmd_pkg::S_ERR;
            kind_d = gyro_cmd_pkg::MSG_SYNTAX;
            code_d = `ERR_SYNTAX;
          end else begin
            state_d = gyro_cmd_pkg::S_EXEC;
          end
        end
      end
      gyro_cmd_pkg::S_EXEC: begin
        if (exit_maint_in) begin
          state_d = gyro_cmd_pkg::S_IDLE;
        end else if (cmd_done_in && cmd_err_in != 8'h00) begin
          state_d = gyro_cmd_pkg::S_ERR;
          kind_d = gyro_cmd_pkg::MSG_PARAM;
          code_d = cmd_err_in;
        end else if (cmd_done_in) begin
          state_d = gyro_cmd_pkg::S_PROMPT;
        end
      end
      gyro_cmd_pkg::S_INFO: begin
        if (cmd_done_in) state_d = gyro_cmd_pkg::S_PROMPT;
      end
      gyro_cmd_pkg::S_ERR: begin
        if (emit && emit_last) state_d = gyro_cmd_pkg::S_PROMPT;
      end
      gyro_cmd_pkg::S_PROMPT: begin
        if (emit && emit_last) state_d = gyro_cmd_pkg::S_IDLE;
      end
      default: state_d = gyro_cmd_pkg::S_IDLE;
    endcase
  end

  wire maint_d = (maint_q || (enter && !maint_q)) &&
                 !(exit_maint_in && state_q == gyro_cmd_pkg::S_EXEC);
  wire room = fifo_level < FW'(FIFO_DEPTH - 2);

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state_q <= gyro_cmd_pkg::S_IDLE;
      kind_q <= gyro_cmd_pkg::MSG_UNKNOWN;
      code_q <= 8'h00;
      idx_q <= 5'd0;
      maint_q <= 1'b0;
      rx_ready_q <= 1'b0;
    end else begin
      state_q <= state_d;
      kind_q <= kind_d;
      code_q <= code_d;
      if (state_d != state_q) idx_q <= 5'd0;
      else if (emit) idx_q <= idx_q + 5'd1;
      maint_q <= maint_d;
      rx_ready_q <= !maint_d ||
                    (state_d == gyro_cmd_pkg::S_IDLE && room);
    end
  end

  // ----------------------------------------------------------
  // streaming requests
  // ----------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      s_len_q <= 4'h0;
      kw_ok_q <= 1'b1;
      first_q <= 8'h00;
      cfg_pend_q <= 1'b0;
      err_pend_q <= 1'b0;
      maint_req_q <= 1'b0;
      trig_s1_q <= 1'b0;
      trig_s2_q <= 1'b0;
      trig_s3_q <= 1'b0;
      send_cfg_q <= 1'b0;
      send_err_q <= 1'b0;
      clr_err_q <= 1'b0;
      reset_q <= 1'b0;
      info_q <= 1'b0;
    end else begin
      trig_s1_q <= ext_trig_in;
      trig_s2_q <= trig_s1_q;
      trig_s3_q <= trig_s2_q;
      if (s_take && is_cr) begin
        s_len_q <= 4'h0;
        kw_ok_q <= 1'b1;
      end else if (s_take) begin
        if (s_len_q == 4'h0) first_q <= rx_data_in;
        kw_ok_q <= kw_ok_q && s_len_q < `KEYWORD_LEN &&
                   rx_data_in == kw_byte(s_len_q);
        if (s_len_q != 4'hf) s_len_q <= s_len_q + 4'h1;
      end
      send_cfg_q <= slot && cfg_pend_q && !maint_q;
      send_err_q <= slot && err_pend_q && !cfg_pend_q && !maint_q;
      cfg_pend_q <= req_cfg || (cfg_pend_q && !(slot && !maint_q));
      err_pend_q <= req_err ||
                    (err_pend_q && !(slot && !cfg_pend_q && !maint_q));
      clr_err_q <= err_dgram_done_in;
      reset_q <= req_rst;
      maint_req_q <= (maint_req_q || req_kw) && !enter;
      info_q <= enter && !maint_q;
    end
  end

  // ----------------------------------------------------------
  // maintenance line buffer
  // ----------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (m_store) cbuf[m_len_q] <= rx_data_in;
  end
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      m_len_q <= '0;
      cmd_v_q <= 1'b0;
      letter_q <= 8'h00;
      plen_q <= '0;
      pdata_q <= 8'h00;
    end else begin
      if (enter || m_cr) m_len_q <= '0;
      else if (m_bs && m_len_q != '0) m_len_q <= m_len_q - LW'(1);
      else if (m_store) m_len_q <= m_len_q + LW'(1);
      cmd_v_q <= state_q == gyro_cmd_pkg::S_IDLE &&
                 state_d == gyro_cmd_pkg::S_EXEC;
      if (m_cr) begin
        letter_q <= cbuf[0];
        plen_q <= m_len_q;
      end
      pdata_q <= param_addr_in < LW'(BUF_LEN) ? cbuf[param_addr_in] : 8'h00;
    end
  end

  // ----------------------------------------------------------
  // transmit fifo
  // ----------------------------------------------------------
  char_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .in_valid_in(wr_valid),
    .in_ready_out(fifo_ready),
    .in_data_in(wr_data),
    .out_valid_out(tx_valid_out),
    .out_ready_in(tx_ready_in),
    .out_data_out(tx_data_out),
    .level_out(fifo_level)
  );

  assign rx_ready_out = rx_ready_q;
  assign send_config_out = send_cfg_q;
  assign send_exterr_out = send_err_q;
  assign clear_errors_out = clr_err_q;
  assign unit_reset_out = reset_q;
  assign maint_mode_out = maint_q;
  assign measure_drop_out = maint_q;
  assign info_req_out = info_q;
  assign cmd_valid_out = cmd_v_q;
  assign cmd_letter_out = letter_q;
  assign param_len_out = plen_q;
  assign param_data_out = pdata_q;

  // ----------------------------------------------------------
  // assertions
  // ----------------------------------------------------------
  sequence q_prompt;
    (in_prompt && idx_q == 5'd0 && emit && wr_data == `CH_CR)
      ##[1:40] (in_prompt && emit && wr_data == `CH_GT);
  endsequence
  property p_cfg_slot;
    @(posedge clk_in) disable iff (rst_in)
      (slot && cfg_pend_q && !maint_q) |=>
        send_config_out && (!cfg_pend_q || $past(req_cfg));
  endproperty
  a_cfg_slot: assert property (p_cfg_slot)
    else $error("config datagram not sent at slot");
  property p_err_slot;
    @(posedge clk_in) disable iff (rst_in)
      (slot && err_pend_q && !cfg_pend_q && !maint_q) |=> send_exterr_out;
  endproperty
  a_err_slot: assert property (p_err_slot)
    else $error("error datagram not sent at slot");
  property p_clear;
    @(posedge clk_in) disable iff (rst_in)
      err_dgram_done_in |=> clear_errors_out;
  endproperty
  a_clear: assert property (p_clear)
    else $error("errors not cleared after datagram");
  property p_reset;
    @(posedge clk_in) disable iff (rst_in)
      unit_reset_out |-> $past(s_one) && $past(first_q) == `CH_UP_R;
  endproperty
  a_reset: assert property (p_reset)
    else $error("unit reset without request");
  property p_wait_dgram;
    @(posedge clk_in) disable iff (rst_in)
      (maint_req_q && dgram_busy_in && !maint_q) |=> !maint_q;
  endproperty
  a_wait_dgram: assert property (p_wait_dgram)
    else $error("mode switched during datagram");
  property p_echo;
    @(posedge clk_in) disable iff (rst_in)
      m_take |-> wr_valid && wr_data == rx_data_in && fifo_ready;
  endproperty
  a_echo: assert property (p_echo)
    else $error("received character not echoed");
  property p_prompt;
    @(posedge clk_in) disable iff (rst_in)
      (in_prompt && idx_q == 5'd0 && emit) |-> q_prompt;
  endproperty
  a_prompt: assert property (p_prompt)
    else $error("prompt not cr then greater-than");
  property p_buf_len;
    @(posedge clk_in) disable iff (rst_in)
      m_len_q <= LW'(BUF_LEN);
  endproperty
  a_buf_len: assert property (p_buf_len)
    else $error("input buffer overrun");
  property p_no_echo;
    @(posedge clk_in) disable iff (rst_in)
      !maint_q |-> !wr_valid;
  endproperty
  a_no_echo: assert property (p_no_echo)
    else $error("output in streaming mode");
  property p_err_head;
    @(posedge clk_in) disable iff (rst_in)
      (in_err && emit && idx_q == 5'd0) |-> wr_data == `CH_UP_E;
  endproperty
  a_err_head: assert property (p_err_head)
    else $error("error reply does not start with E");
endmodule // gyro_serial_command_parser

// ==== sim/serial_host_model.sv ====
// host side model: sends characters and collects the replies
`timescale 1ns/1ps
module serial_host_model (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // characters to the device
  output logic rx_valid_out,
  output logic [7:0] rx_data_out,
  input wire logic rx_ready_in,
  // characters from the device
  input wire logic tx_valid_in,
  input wire logic [7:0] tx_data_in,
  output logic tx_ready_out
);
  logic [7:0] got_q[$];
  initial begin
    rx_valid_out = 1'b0;
    rx_data_out = 8'h00;
    tx_ready_out = 1'b0;
  end
  // holds the character until the edge that takes it
  task automatic send_char(input logic [7:0] c);
    int n;
    n = 0;
    rx_valid_out = 1'b1;
    rx_data_out = c;
    do begin
      @(posedge clk_in);
      n++;
    end while (rx_ready_in !== 1'b1 && n < 500);
    #1;
  endtask
  // a released line shows the inverse of the last character
  task automatic go_idle();
    rx_valid_out = 1'b0;
    rx_data_out = ~rx_data_out;
  endtask
  // collects replies, stalling at random
  always @(posedge clk_in) begin
    if (tx_valid_in === 1'b1 && tx_ready_out === 1'b1) begin
      got_q.push_back(tx_data_in);
    end
    #1;
    tx_ready_out = !rst_in && ($urandom_range(3) != 0);
  end
endmodule // serial_host_model

// ==== sim/test_gyro_serial_command_parser.sv ====
// self-checking bench of the serial command interpreter
`timescale 1ns/1ps
`include "gyro_cmd_regs.svh"
module test_gyro_serial_command_parser;
  logic clk_in = 1'b0;
  logic rst_in, rx_valid_in, rx_ready_out, tx_valid_out, tx_ready_in;
  logic [7:0] rx_data_in, tx_data_out, cmd_letter_out, param_data_out;
  logic ext_trig_mode_in, slot_in, ext_trig_in, dgram_busy_in;
  logic err_dgram_done_in, send_config_out, send_exterr_out;
  logic clear_errors_out, unit_reset_out, maint_mode_out, measure_drop_out;
  logic info_req_out, cmd_valid_out, cmd_done_in, exit_maint_in;
  logic [6:0] param_len_out, param_addr_in, cap_len;
  logic [7:0] cmd_err_in, cap_letter, e;
  int n_fail, compares, cycles, n_cfg, n_err, n_clr, n_rst, n_info;
  int n_cmd, n_used, k;
  string s, lt;
  always #12.5 clk_in = ~clk_in;
  gyro_serial_command_parser gyro_serial_command_parser_i (.*);
  serial_host_model serial_host_model_i (
    .clk_in(clk_in), .rst_in(rst_in), .rx_valid_out(rx_valid_in),
    .rx_data_out(rx_data_in), .rx_ready_in(rx_ready_out),
    .tx_valid_in(tx_valid_out), .tx_data_in(tx_data_out),
    .tx_ready_out(tx_ready_in));
  // ---------------------------------------------------------------
  // pulse counters and timeout
  // ---------------------------------------------------------------
  always @(posedge clk_in) begin
    cycles++;
    n_cfg += (send_config_out === 1'b1);
    n_err += (send_exterr_out === 1'b1);
    n_clr += (clear_errors_out === 1'b1);
    n_rst += (unit_reset_out === 1'b1);
    n_info += (info_req_out === 1'b1);
    if (cmd_valid_out === 1'b1) begin
      n_cmd++;
      cap_letter = cmd_letter_out;
      cap_len = param_len_out;
    end
    if (cycles == 60000) begin
      n_fail++;
      give_verdict();
    end
  end
  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic send_str(input string t);
    for (int i = 0; i < t.len(); i++) serial_host_model_i.send_char(t[i]);
    serial_host_model_i.go_idle();
    tick(1);
  endtask
  // leading n characters of the entry keyword, then carriage return
  task automatic send_kw(input int n);
    logic [87:0] kw;
    kw = `KEYWORD;
    for (int i = 10; i > 10 - n; i--) begin
      serial_host_model_i.send_char(kw[i*8+:8]);
    end
    serial_host_model_i.send_char(8'h0d);
    serial_host_model_i.go_idle();
    tick(1);
  endtask
  task automatic expect_tx(input string t);
    int n;
    for (int i = 0; i < t.len(); i++) begin
      n = 0;
      while (serial_host_model_i.got_q.size() == 0 && n < 400) begin
        tick(1);
        n++;
      end
      if (serial_host_model_i.got_q.size() == 0) chk(8'hxx, t[i]);
      else chk(serial_host_model_i.got_q.pop_front(), t[i]);
    end
  endtask
  task automatic wait_cmd(input logic [7:0] l, input logic [6:0] len);
    int n;
    n = 0;
    while (n_cmd == n_used && n < 300) begin
      tick(1);
      n++;
    end
    chk(8'(n_cmd), 8'(n_used + 1));
    n_used = n_cmd;
    chk(cap_letter, l);
    chk({1'b0, cap_len}, {1'b0, len});
  endtask
  task automatic finish_cmd(input logic [7:0] er, input logic ex);
    tick(1 + $urandom_range(5));
    cmd_err_in = er;
    exit_maint_in = ex;
    cmd_done_in = 1'b1;
    tick(1);
    cmd_done_in = 1'b0;
    exit_maint_in = 1'b0;
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] exp);
    param_addr_in = a;
    tick(2);
    chk(param_data_out, exp);
  endtask
  task automatic slot();
    slot_in = 1'b1;
    tick(1);
    slot_in = 1'b0;
    tick(4);
  endtask
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    rst_in = 1'b1;
    {ext_trig_mode_in, slot_in, ext_trig_in, dgram_busy_in} = 4'h0;
    {err_dgram_done_in, cmd_done_in, exit_maint_in} = 3'h0;
    param_addr_in = 7'h00;
    cmd_err_in = 8'h00;
    lt = "iacdtrufmsxz?";
    k = $urandom(99902);
    tick(8);
    chk(rx_ready_out, 8'h00);
    chk(tx_valid_out, 8'h00);
    chk(maint_mode_out, 8'h00);
    tick(8);
    rst_in = 1'b0;
    tick(2);
    chk(rx_ready_out, 8'h01);
    send_str("C\015");
    tick(4);
    chk(8'(n_cfg), 8'h00);
    slot();
    chk(8'(n_cfg), 8'h01);
    send_str("C\015");
    send_str("E\015");
    slot();
    chk(8'(n_cfg), 8'h02);
    chk(8'(n_err), 8'h00);
    slot();
    chk(8'(n_err), 8'h01);
    err_dgram_done_in = 1'b1;
    tick(1);
    err_dgram_done_in = 1'b0;
    tick(3);
    chk(8'(n_clr), 8'h01);
    ext_trig_mode_in = 1'b1;
    send_str("E\015");
    ext_trig_in = 1'b1;
    tick(8);
    chk(8'(n_err), 8'h02);
    ext_trig_in = 1'b0;
    send_str("C\015");
    ext_trig_in = 1'b1;
    tick(8);
    chk(8'(n_cfg), 8'h03);
    {ext_trig_in, ext_trig_mode_in} = 2'h0;
    send_str("R\015");
    tick(3);
    chk(8'(n_rst), 8'h01);
    send_str("X\015");
    send_str("c\015");
    send_kw(10);
    slot();
    chk({8'(n_cfg + n_rst), maint_mode_out}, {8'h04, 1'b0});
    chk(8'(serial_host_model_i.got_q.size()), 8'h00);
    send_str("C\015");
    dgram_busy_in = 1'b1;
    send_kw(11);
    tick(6);
    chk(maint_mode_out, 8'h00);
    dgram_busy_in = 1'b0;
    tick(3);
    chk(maint_mode_out, 8'h01);
    chk(8'(n_info), 8'h01);
    chk(measure_drop_out, 8'h01);
    slot();
    chk(8'(n_cfg), 8'h03);
    finish_cmd(8'h00, 1'b0);
    expect_tx("\015>");
    k = $urandom_range(12);
    for (int i = 0; i < 13; i++) begin
      s = lt.substr((i + k) % 13, (i + k) % 13);
      send_str({s, "\015"});
      wait_cmd(s[0], 7'h01);
      finish_cmd(8'h00, 1'b0);
      expect_tx({s, "\015\015>"});
    end
    send_str("q\015");
    expect_tx("q\015E001 UNKNOWN COMMAND\015\015>");
    send_str("ab\015");
    expect_tx("ab\015E002 BAD SYNTAX\015\015>");
    e = 8'($urandom_range(255, 1));
    send_str("t 5,6\015");
    wait_cmd("t", 7'h05);
    rd(7'h02, "5");
    rd(7'h03, ",");
    rd(7'h04, "6");
    finish_cmd(e, 1'b0);
    s = {"t 5,6\015", $sformatf("E%03d INVALID PARAMETER\015", e), "\015>"};
    expect_tx(s);
    send_str("xz\010\015");
    wait_cmd("x", 7'h01);
    finish_cmd(8'h00, 1'b0);
    expect_tx("xz\010\015\015>");
    send_str("\010\015");
    expect_tx("\010\015\015>");
    s = "m ";
    repeat (84) s = {s, "1"};
    s = {s, "\010\015"};
    send_str(s);
    wait_cmd("m", 7'd79);
    rd(7'h00, "m");
    rd(7'd78, "1");
    rd(7'd80, 8'h00);
    finish_cmd(8'h00, 1'b0);
    expect_tx({s, "\015>"});
    send_str("x 0\015");
    wait_cmd("x", 7'h03);
    finish_cmd(8'h00, 1'b1);
    tick(100);
    chk(maint_mode_out, 8'h00);
    serial_host_model_i.got_q.delete();
    send_str("R\015");
    tick(3);
    chk(8'(n_rst), 8'h02);
    chk(8'(serial_host_model_i.got_q.size()), 8'h00);
    give_verdict();
  end
endmodule // test_gyro_serial_command_parser
